// ===== pkg/bcc_consts.vh
// constants for the bus controller configuration register bank
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH
`define BCC_PORT_INDEX      16'h0022
`define BCC_PORT_DATA       16'h0023
`define BCC_IDX_PROC_CLK    8'h60
`define BCC_IDX_CMD_DELAY   8'h61
`define BCC_IDX_WAIT_STATE  8'h62
`define BCC_RST_PROC_CLK    8'h00
`define BCC_RST_CMD_DELAY   8'h45
`define BCC_RST_WAIT_STATE  8'h3C
`define BCC_MASK_PROC_CLK   8'h35
`define BCC_MASK_CMD_DELAY  8'hFF
`define BCC_MASK_WAIT_STATE 8'h3F
`define BCC_BIT_TIMEOUT     0
`define BCC_BIT_NMI_EN      2
`define BCC_BIT_CLK_SEL     4
`define BCC_BIT_ALT_RESET   5
`define BCC_CPU_RESET_CYC   5'h10
`define BCC_TIMEOUT_CYC     8'h80
`define BCC_BUS_CLK_HALF    2'h0
`define BCC_BUS_CLK_FULL    2'h1
`define BCC_BUS_CLK_EXT     2'h2
`endif

// ===== hw/bcc_cycle_timer.v
// cycle counter that fires once a threshold is reached while armed
`timescale 1ns/10ps
`default_nettype none
module bcc_cycle_timer #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             srst,
    input  wire             start,
    input  wire             stop,
    input  wire [WIDTH-1:0] limit,
    output reg              running,
    output reg              done
);
    reg [WIDTH-1:0] count;

    // start loads, counting runs while armed, done pulses at limit
    always @(posedge clk) begin
        if (srst) begin
            count   <= {WIDTH{1'b0}};
            running <= 1'b0;
            done    <= 1'b0;
        end else begin
            done <= 1'b0;
            if (stop) begin
                running <= 1'b0;
                count   <= {WIDTH{1'b0}};
            end else if (start) begin
                running <= 1'b1;
                count   <= {{(WIDTH-1){1'b0}}, 1'b1};
            end else if (running) begin
                if (count == limit) begin
                    running <= 1'b0;
                    done    <= 1'b1;
                end else begin
                    count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule
`default_nettype wire

// ===== hw/bcc_config_regs.v
// indexed configuration register bank of the bus controller
`timescale 1ns/10ps
`default_nettype none
`include "bcc_consts.vh"
module bcc_config_regs #(
    parameter [1:0] REVISION = 2'h0  // arbitrary value
) (
    input  wire        clk,
    input  wire        srst,
    input  wire [15:0] io_addr,
    input  wire [7:0]  io_wdata,
    input  wire        io_wr,
    input  wire        io_rd,
    input  wire        at_cycle_flag,
    input  wire        ready_n,
    output reg  [7:0]  io_rdata,
    output reg         io_rvalid,
    output reg         cpu_reset,
    output reg         timeout_nmi,
    output reg         proc_clk_sel_bus,
    output reg  [1:0]  io_cmd_delay,
    output reg  [1:0]  mem8_cmd_delay,
    output reg  [1:0]  mem16_cmd_delay,
    output reg         quick_mode_en,
    output reg         addr_hold_en,
    output reg  [1:0]  bus_clk_sel,
    output reg  [2:0]  mem8_wait_states,
    output reg  [1:0]  mem16_wait_states
);
    reg  [7:0] index;
    reg        index_valid;
    reg  [7:0] proc_clk_reg;
    reg  [7:0] cmd_delay_reg;
    reg  [7:0] wait_reg;
    reg        flag_s1;
    reg        flag_s2;
    reg        flag_d;
    reg        ready_s1;
    reg        ready_s2;
    reg  [4:0] reset_cnt;
    reg  [7:0] next_rdata;
    wire       data_wr;
    wire       data_rd;
    wire       cycle_start;
    wire       cycle_end;
    wire       timeout_hit;
    wire       timer_running;
    wire [7:0] wdata_proc;

    assign data_wr = io_wr && (io_addr == `BCC_PORT_DATA) && index_valid;
    assign data_rd = io_rd && (io_addr == `BCC_PORT_DATA) && index_valid;

    // index latch: each data access consumes the index
    always @(posedge clk) begin
        if (srst) begin
            index       <= 8'h00;
            index_valid <= 1'b0;
        end else if (io_wr && io_addr == `BCC_PORT_INDEX) begin
            index       <= io_wdata;
            index_valid <= 1'b1;
        end else if ((io_wr || io_rd) && io_addr == `BCC_PORT_DATA) begin
            index_valid <= 1'b0;
        end
    end

    // two-flop synchronisers for the local bus inputs
    always @(posedge clk) begin
        if (srst) begin
            flag_s1  <= 1'b0;
            flag_s2  <= 1'b0;
            flag_d   <= 1'b0;
            ready_s1 <= 1'b1;
            ready_s2 <= 1'b1;
        end else begin
            flag_s1  <= at_cycle_flag;
            flag_s2  <= flag_s1;
            flag_d   <= flag_s2;
            ready_s1 <= ready_n;
            ready_s2 <= ready_s1;
        end
    end

    assign cycle_start = flag_s2 && !flag_d;
    assign cycle_end   = !ready_s2;

    // times each local cycle from the flag to READY
    bcc_cycle_timer #(
        .WIDTH(8)
    ) u_timeout (
        .clk    (clk),
        .srst   (srst),
        .start  (cycle_start),
        .stop   (cycle_end),
        .limit  (`BCC_TIMEOUT_CYC),
        .running(timer_running),
        .done   (timeout_hit)
    );

    // only writable bits of the processor clock register are stored
    assign wdata_proc = io_wdata & `BCC_MASK_PROC_CLK & 8'hFE;

    // register writes; the timeout flag is hardware set, software clear
    always @(posedge clk) begin
        if (srst) begin
            proc_clk_reg  <= `BCC_RST_PROC_CLK;
            cmd_delay_reg <= `BCC_RST_CMD_DELAY;
            wait_reg      <= `BCC_RST_WAIT_STATE;
        end else begin
            if (data_wr && index == `BCC_IDX_PROC_CLK) begin
                proc_clk_reg <= {2'b00, wdata_proc[5:1],
                                 proc_clk_reg[`BCC_BIT_TIMEOUT] & io_wdata[0]};
            end
            if (timeout_hit) begin
                proc_clk_reg[`BCC_BIT_TIMEOUT] <= 1'b1;
            end
            if (data_wr && index == `BCC_IDX_CMD_DELAY) begin
                cmd_delay_reg <= io_wdata & `BCC_MASK_CMD_DELAY;
            end
            if (data_wr && index == `BCC_IDX_WAIT_STATE) begin
                wait_reg <= io_wdata & `BCC_MASK_WAIT_STATE;
            end
        end
    end

    // alternate CPU reset pulse on a rising write of bit 5
    always @(posedge clk) begin
        if (srst) begin
            reset_cnt <= 5'h00;
            cpu_reset <= 1'b0;
        end else if (data_wr && index == `BCC_IDX_PROC_CLK &&
                     io_wdata[`BCC_BIT_ALT_RESET] &&
                     !proc_clk_reg[`BCC_BIT_ALT_RESET]) begin
            reset_cnt <= `BCC_CPU_RESET_CYC;
            cpu_reset <= 1'b1;
        end else if (reset_cnt != 5'h00) begin
            reset_cnt <= reset_cnt - 5'h01;
            cpu_reset <= (reset_cnt != 5'h01);
        end else begin
            cpu_reset <= 1'b0;
        end
    end

    // read multiplexer
    always @* begin
        next_rdata = 8'h00;
        case (index)
            `BCC_IDX_PROC_CLK:   next_rdata = {REVISION, proc_clk_reg[5:0]};
            `BCC_IDX_CMD_DELAY:  next_rdata = cmd_delay_reg;
            `BCC_IDX_WAIT_STATE: next_rdata = wait_reg;
            default:             next_rdata = 8'h00;
        endcase
    end

    // registered read data and decoded control outputs
    always @(posedge clk) begin
        if (srst) begin
            io_rdata          <= 8'h00;
            io_rvalid         <= 1'b0;
            timeout_nmi       <= 1'b0;
            proc_clk_sel_bus  <= 1'b0;
            io_cmd_delay      <= 2'h1;
            mem8_cmd_delay    <= 2'h1;
            mem16_cmd_delay   <= 2'h0;
            quick_mode_en     <= 1'b0;
            addr_hold_en      <= 1'b0;
            bus_clk_sel       <= 2'h0;
            mem8_wait_states  <= 3'h5;
            mem16_wait_states <= 2'h3;
        end else begin
            io_rvalid <= data_rd;
            if (data_rd) begin
                io_rdata <= next_rdata;
            end
            timeout_nmi       <= proc_clk_reg[`BCC_BIT_NMI_EN] &
                                 proc_clk_reg[`BCC_BIT_TIMEOUT];
            proc_clk_sel_bus  <= proc_clk_reg[`BCC_BIT_CLK_SEL];
            io_cmd_delay      <= cmd_delay_reg[1:0];
            mem8_cmd_delay    <= cmd_delay_reg[3:2];
            mem16_cmd_delay   <= cmd_delay_reg[5:4];
            quick_mode_en     <= ~cmd_delay_reg[6];
            addr_hold_en      <= cmd_delay_reg[7] & ~cmd_delay_reg[6] ? 1'b0 :
                                 cmd_delay_reg[7] &
                                 (wait_reg[1:0] == `BCC_BUS_CLK_HALF);
            bus_clk_sel       <= wait_reg[1:0];
            mem8_wait_states  <= {1'b0, wait_reg[3:2]} + 3'h2;
            mem16_wait_states <= wait_reg[5:4];
        end
    end
endmodule
`default_nettype wire

// ===== testbench/bcc_config_regs_props.sv
// assertion checker for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
module bcc_config_regs_props (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic       at_cycle_flag,
    input wire logic       ready_n,
    input wire logic [7:0] io_rdata,
    input wire logic       io_rvalid,
    input wire logic       cpu_reset,
    input wire logic       timeout_nmi,
    input wire logic [1:0] io_cmd_delay,
    input wire logic       quick_mode_en,
    input wire logic       addr_hold_en,
    input wire logic [1:0] bus_clk_sel,
    input wire logic [2:0] mem8_wait_states
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    logic [7:0] rcnt;
    logic [7:0] tcnt;
    // lengths of the reset pulse and of an unanswered local cycle
    always_ff @(posedge clk) begin
        rcnt <= (srst || !cpu_reset) ? 8'h00 : rcnt + 8'h01;
        tcnt <= (srst || !ready_n || !at_cycle_flag || tcnt == 8'hFF) ? tcnt & 8'h00 : tcnt + 8'h01;
    end
    property p_rv; io_rvalid |-> $past(io_rd); endproperty
    a_rv: assert property (p_rv) else $error("read valid without read");
    property p_rd; $changed(io_rdata) |-> io_rvalid; endproperty
    a_rd: assert property (p_rd) else $error("read data moved alone");
    property p_rlen; $fell(cpu_reset) |-> rcnt == 8'h10; endproperty
    a_rlen: assert property (p_rlen) else $error("cpu reset length wrong");
    property p_rmax; cpu_reset |-> rcnt < 8'h10; endproperty
    a_rmax: assert property (p_rmax) else $error("cpu reset too long");
    property p_rcause; $rose(cpu_reset) |-> $past(io_wr); endproperty
    a_rcause: assert property (p_rcause) else $error("cpu reset without write");
    property p_nmi; $rose(timeout_nmi) |-> tcnt >= 8'h80 || $past(io_wr, 2); endproperty
    a_nmi: assert property (p_nmi) else $error("early timeout");
    property p_hold; addr_hold_en |-> !quick_mode_en && bus_clk_sel == 2'h0; endproperty
    a_hold: assert property (p_hold) else $error("hold outside normal mode");
    property p_ws; mem8_wait_states >= 3'h2 && mem8_wait_states <= 3'h5; endproperty
    a_ws: assert property (p_ws) else $error("wait count out of range");
    property p_fld; $changed({io_cmd_delay, bus_clk_sel}) |-> $past(io_wr, 2); endproperty
    a_fld: assert property (p_fld) else $error("field moved without write");
    cover property ($rose(cpu_reset));
    cover property ($rose(timeout_nmi));
    cover property (io_rvalid);
endmodule
bind bcc_config_regs bcc_config_regs_props u_props (.*);
`default_nettype wire

// ===== testbench/bcc_config_regs_tb.sv
// self-checking bench for the configuration register bank
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, a, b); end end
module bcc_config_regs_tb;
    logic clk = 0, srst = 1, io_wr = 0, io_rd = 0, at_cycle_flag = 0, ready_n = 1;
    logic [15:0] io_addr = 0;
    logic [7:0]  io_wdata = 0, v, w, r, e, io_rdata;
    logic [7:0]  q[$];
    logic [31:0] seed = 32'hd631;
    wire logic io_rvalid, cpu_reset, timeout_nmi, proc_clk_sel_bus, quick_mode_en, addr_hold_en;
    wire logic [1:0] io_cmd_delay, mem8_cmd_delay, mem16_cmd_delay, bus_clk_sel, mem16_wait_states;
    wire logic [2:0] mem8_wait_states;
    int mismatches = 0, n_checks = 0, cyc = 0, i, k;
    bcc_config_regs uut (.*);
    always #12.5 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            mismatches++;
            conclude();
        end
    end
    task conclude;
        if (mismatches == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task strobe(input [15:0] a, input [7:0] d, input rd);
        @(posedge clk); #2; io_addr = a; io_wdata = d; io_wr = !rd; io_rd = rd;
        @(posedge clk); #2; io_wr = 0; io_rd = 0;
    endtask
    task wreg(input [7:0] idx, input [7:0] d);
        strobe(16'h0022, idx, 0); strobe(16'h0023, d, 0);
    endtask
    task rreg(input [7:0] idx, input [7:0] x);
        strobe(16'h0022, idx, 0); q.push_back(x); strobe(16'h0023, 8'h00, 1);
    endtask
    task cycles(input int n);
        repeat (n) @(posedge clk); #2;
    endtask
    // read result watcher
    always @(posedge clk) if (io_rvalid === 1'b1) begin
        if (q.size() == 0) `CHK(io_rvalid, 1'b0)
        else begin
            e = q.pop_front(); `CHK(io_rdata, e)
        end
    end
    initial begin
        cycles(4); srst = 0;
        rreg(8'h60, 8'h00);
        rreg(8'h61, 8'h45);
        rreg(8'h62, 8'h3C);
        rreg(8'h63, 8'h00);
        strobe(16'h0023, 8'h00, 1);
        `CHK({mem8_wait_states, mem16_wait_states, io_cmd_delay}, 7'h5D)
        `CHK({mem8_cmd_delay, mem16_cmd_delay, quick_mode_en, addr_hold_en}, 6'h10)
        for (i = 0; i < 4; i++) begin
            r = $random(seed);
            v = {r[7:6], i[1:0], i[1:0], i[1:0]};
            w = {2'h0, i[1:0], i[1:0], (i == 3) ? 2'h0 : i[1:0]};
            wreg(8'h61, v); wreg(8'h62, w);
            strobe(16'h0023, ~v, 0);
            rreg(8'h61, v);
            rreg(8'h62, w);
            `CHK({io_cmd_delay, mem8_cmd_delay, mem16_cmd_delay}, v[5:0])
            `CHK({quick_mode_en, addr_hold_en}, {~v[6], v[7] & v[6] & (w[1:0] == 2'h0)})
            `CHK({bus_clk_sel, mem16_wait_states}, {w[1:0], i[1:0]})
            `CHK(mem8_wait_states, {1'b0, i[1:0]} + 3'h2)
        end
        wreg(8'h60, 8'hD4); rreg(8'h60, 8'h14);
        `CHK(proc_clk_sel_bus, 1'b1)
        // one local cycle left unanswered
        at_cycle_flag = 1; i = 0;
        while (timeout_nmi !== 1'b1 && i < 300) begin cycles(1); i++; end
        `CHK({i >= 128, timeout_nmi}, 2'h3)
        ready_n = 0; at_cycle_flag = 0; rreg(8'h60, 8'h15);
        wreg(8'h60, 8'h14); rreg(8'h60, 8'h14);
        `CHK(timeout_nmi, 1'b0)
        // two short local cycles, each answered in time
        for (k = 0; k < 2; k++) begin
            ready_n = 1; at_cycle_flag = 1; cycles(100); ready_n = 0; at_cycle_flag = 0; cycles(6);
        end
        `CHK(timeout_nmi, 1'b0)
        at_cycle_flag = 0; ready_n = 1;
        wreg(8'h60, 8'h34); i = 0;
        while (cpu_reset !== 1'b1 && i < 8) begin cycles(1); i++; end
        i = 0;
        while (cpu_reset === 1'b1 && i < 40) begin cycles(1); i++; end
        `CHK(i, 16)
        cycles(4);
        `CHK(q.size(), 0)
        conclude();
    end
endmodule
`default_nettype wire
